// ---- rtl/sce_pkg.sv ----
// constants shared by the serial channel event and control logic
// assumes one 250 MHz clock and a 32-bit axi4-lite register port

package sce_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] sce_off_channel_control = 8'h10;
  localparam logic [7:0] sce_off_protocol_control_low = 8'h18;
  localparam logic [7:0] sce_off_protocol_control_high = 8'h1C;
  localparam logic [7:0] sce_off_protocol_status = 8'h20;
  localparam logic [7:0] sce_off_status_clear = 8'h24;
  localparam logic [7:0] sce_off_node_pointer_low = 8'h28;
  localparam logic [7:0] sce_off_node_pointer_high = 8'h2C;

  // ==========================================================
  // reset values and writable masks
  localparam logic [15:0] sce_rst_channel_control = 16'h0000;
  localparam logic [15:0] sce_rst_protocol_control = 16'h0000;
  localparam logic [15:0] sce_rst_node_pointer = 16'h0000;
  localparam logic [15:0] sce_wmask_channel_control = 16'hFF0F;
  localparam logic [15:0] sce_wmask_node_pointer_low = 16'h7777;
  localparam logic [15:0] sce_wmask_node_pointer_high = 16'h0007;

  // ==========================================================
  // channel control fields
  localparam int unsigned sce_pos_mode = 0;
  localparam int unsigned sce_pos_parity_mode = 8;
  localparam int unsigned sce_pos_rx_start_en = 10;
  localparam int unsigned sce_pos_data_lost_en = 11;
  localparam int unsigned sce_pos_tx_shift_en = 12;
  localparam int unsigned sce_pos_tx_buffer_en = 13;
  localparam int unsigned sce_pos_receive_en = 14;
  localparam int unsigned sce_pos_alt_receive_en = 15;

  // operating mode codes
  localparam logic [3:0] sce_mode_disabled = 4'h0;
  localparam logic [3:0] sce_mode_sync = 4'h1;
  localparam logic [3:0] sce_mode_i2s = 4'h2;
  localparam logic [3:0] sce_mode_async = 4'h3;
  localparam logic [3:0] sce_mode_i2c = 4'h4;

  // parity mode codes
  localparam logic [1:0] sce_parity_none = 2'h0;
  localparam logic [1:0] sce_parity_even = 2'h2;
  localparam logic [1:0] sce_parity_odd = 2'h3;

  // ==========================================================
  // node pointer field positions
  localparam int unsigned sce_pos_tx_shift_ptr = 0;
  localparam int unsigned sce_pos_tx_buffer_ptr = 4;
  localparam int unsigned sce_pos_receive_ptr = 8;
  localparam int unsigned sce_pos_alt_receive_ptr = 12;
  localparam int unsigned sce_pos_protocol_ptr = 0;
  localparam int unsigned sce_num_sr = 6;

  // ==========================================================
  // axi responses
  localparam logic [1:0] sce_resp_okay = 2'h0;
  localparam logic [1:0] sce_resp_slverr = 2'h2;
endpackage

// ---- rtl/sce_flag_bank.sv ----
// sticky event indication flags of the serial channel
// assumes set and clear strobes are one-cycle pulses on aclk

`timescale 1ns/1ns

// ==========================================================
// flag bank
module sce_flag_bank
  import sce_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] set_flags,
  input wire logic [15:0] clear_flags,
  output logic [15:0] flags
);
  typedef struct packed {
    logic [15:0] flags;
  } sce_flag_state_type;

  sce_flag_state_type state;
  sce_flag_state_type next_state;
  logic [15:0] next_bits;

  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_flag
      // set beats clear so an event in the clearing cycle survives
      assign next_bits[i] = set_flags[i] | (state.flags[i] & ~clear_flags[i]); // [R01] [R16]
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_state.flags = next_bits;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.flags;
endmodule // sce_flag_bank

// ---- rtl/sce_channel_events.sv ----
// event flags, enables, routing and channel control of one serial channel
// assumes protocol engines deliver one-cycle event pulses on aclk
//
// Implementation choice: the AXI4-Lite interface to the registers.

`timescale 1ns/1ns

// ==========================================================
// top module
// Function
// (R01) each protocol event sets its own status bit; clear register bit clears it
// (R02) enabled protocol events raise one common request via protocol pointer
// (R03) async mode: status bits 8..2, enables in low control 7..3
// (R04) sync mode: select-output and select-input frame events, bits 3..2, enables 15..14
// (R05) i2c mode: eight events in status 8..1, enables high control 24..18
// (R06) i2s mode: word-select events in status 6..3, enables 6..4 and 15
// (R07) mode field 3..0 selects protocol; 1 sync, 4 i2c
// (R08) mode zero disables channel and idles every protocol state machine
// (R09) unimplemented or reserved mode code leaves the channel disabled
// (R10) software disables channel before changing protocol, then rewrites controls
// (R11) parity field 9..8: none, reserved, even, odd
// (R12) bit 10 enables receiver start request via transmit buffer pointer
// (R13) bit 11 enables data lost request via protocol pointer
// (R14) bit 12 enables transmit shift request via its own pointer
// (R15) bits 13..15 enable transmit buffer, receive, alternative receive requests
// (R16) flags stay set until cleared and never gate request generation
// (R17) channel control resets to zero; reserved bits read zero
module sce_channel_events
  import sce_pkg::*;
#(
  parameter logic [3:0] protocol_available = 4'hF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic receive_event,
  input wire logic rx_start_event,
  input wire logic alt_receive_event,
  input wire logic tx_shift_event,
  input wire logic tx_buffer_event,
  input wire logic data_lost_event,
  input wire logic [8:1] protocol_event,
  output logic channel_active,
  output logic protocol_force_idle,
  output logic sync_serial_mode,
  output logic async_serial_mode,
  output logic i2c_mode,
  output logic i2s_mode,
  output logic [1:0] parity_mode,
  output logic parity_enable,
  output logic parity_odd,
  output logic [sce_num_sr-1:0] service_request_output
);
  // ==========================================================
  // state
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] channel_control;
    logic [15:0] protocol_control_low;
    logic [15:0] protocol_control_high;
    logic [15:0] node_pointer_low;
    logic [15:0] node_pointer_high;
    logic [sce_num_sr-1:0] service_request;
  } sce_state_type;

  sce_state_type state;
  sce_state_type next_state;

  logic [3:0] mode;
  logic [8:0] proto_valid;
  logic [8:0] proto_en;
  logic [15:0] set_flags;
  logic [15:0] clear_flags;
  logic [15:0] protocol_status_register;
  logic write_fire;
  logic [31:0] read_word;
  logic read_hit;
  logic proto_fire;

  // ==========================================================
  // helpers
  function automatic logic [15:0] sce_merge(
    input logic [15:0] old_value,
    input logic [31:0] data,
    input logic [3:0] strb,
    input logic [15:0] wmask
  );
    logic [15:0] merged;
    merged = old_value;
    if (strb[0]) begin
      merged[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merged[15:8] = data[15:8];
    end
    return merged & wmask;
  endfunction

  function automatic logic [sce_num_sr-1:0] sce_route(
    input logic [sce_num_sr-1:0] vec,
    input logic fire,
    input logic [2:0] ptr
  );
    logic [sce_num_sr-1:0] routed;
    routed = vec;
    // pointer codes beyond the last output reach no request line
    for (int k = 0; k < sce_num_sr; k++) begin
      if (fire && (ptr == 3'(k))) begin
        routed[k] = 1'b1;
      end
    end
    return routed;
  endfunction

  // ==========================================================
  // mode decode
  assign mode = state.channel_control[sce_pos_mode +: 4]; // [R07]

  always_comb begin
    sync_serial_mode = (mode == sce_mode_sync) && protocol_available[0]; // [R07] [R09]
    async_serial_mode = (mode == sce_mode_async) && protocol_available[1]; // [R09]
    i2c_mode = (mode == sce_mode_i2c) && protocol_available[2]; // [R07] [R09]
    i2s_mode = (mode == sce_mode_i2s) && protocol_available[3]; // [R09]
  end

  // zero or reserved codes fall out of every decode above
  assign channel_active = sync_serial_mode | async_serial_mode | i2c_mode | i2s_mode; // [R08] [R09]
  assign protocol_force_idle = ~channel_active; // [R08]

  assign parity_mode = state.channel_control[sce_pos_parity_mode +: 2]; // [R11]
  // the reserved code behaves as no parity
  assign parity_enable = (parity_mode == sce_parity_even) || (parity_mode == sce_parity_odd); // [R11]
  assign parity_odd = (parity_mode == sce_parity_odd); // [R11]

  // ==========================================================
  // protocol event enables per mode
  always_comb begin
    proto_valid = '0;
    proto_en = '0;
    if (async_serial_mode) begin
      proto_valid[8:2] = 7'h7F; // [R03]
      for (int k = 2; k <= 6; k++) begin
        proto_en[k] = state.protocol_control_low[k+1]; // [R03]
      end
      // both frame-finished indications share the top enable
      proto_en[7] = state.protocol_control_low[7]; // [R03]
      proto_en[8] = state.protocol_control_low[7]; // [R03]
    end
    if (sync_serial_mode) begin
      proto_valid[3:2] = 2'h3; // [R04]
      proto_en[2] = state.protocol_control_low[14]; // [R04]
      proto_en[3] = state.protocol_control_low[15]; // [R04]
    end
    if (i2c_mode) begin
      proto_valid[8:1] = 8'hFF; // [R05]
      for (int k = 1; k <= 7; k++) begin
        proto_en[k] = state.protocol_control_high[k+1]; // [R05]
      end
      proto_en[8] = state.protocol_control_high[8]; // [R05]
    end
    if (i2s_mode) begin
      proto_valid[6:3] = 4'hF; // [R06]
      proto_en[3] = state.protocol_control_low[4]; // [R06]
      proto_en[4] = state.protocol_control_low[5]; // [R06]
      proto_en[5] = state.protocol_control_low[6]; // [R06]
      proto_en[6] = state.protocol_control_low[15]; // [R06]
    end
  end

  // ==========================================================
  // flag set and clear
  always_comb begin
    set_flags = '0;
    set_flags[8:1] = protocol_event & proto_valid[8:1]; // [R01]
    set_flags[sce_pos_rx_start_en] = rx_start_event & channel_active;
    set_flags[sce_pos_data_lost_en] = data_lost_event & channel_active;
    set_flags[sce_pos_tx_shift_en] = tx_shift_event & channel_active;
    set_flags[sce_pos_tx_buffer_en] = tx_buffer_event & channel_active;
    set_flags[sce_pos_receive_en] = receive_event & channel_active;
    set_flags[sce_pos_alt_receive_en] = alt_receive_event & channel_active;
  end

  assign write_fire = state.aw_have && state.w_have && !state.bvalid;

  always_comb begin
    clear_flags = '0;
    if (write_fire && (state.aw_addr == sce_off_status_clear)) begin
      clear_flags = sce_merge(16'h0000, state.w_data, state.w_strb, 16'hFFFF); // [R01]
    end
  end

  sce_flag_bank u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_flags(set_flags),
    .clear_flags(clear_flags),
    .flags(protocol_status_register)
  );

  // flags do not take part here, so requests repeat without clearing
  assign proto_fire = |(set_flags[8:1] & proto_en[8:1]); // [R02] [R16]

  // ==========================================================
  // read decode
  always_comb begin
    read_word = '0;
    read_hit = 1'b1;
    case (s_axi_araddr)
      sce_off_channel_control: begin
        read_word[15:0] = state.channel_control; // [R17]
      end
      sce_off_protocol_control_low: begin
        read_word[15:0] = state.protocol_control_low;
      end
      sce_off_protocol_control_high: begin
        read_word[15:0] = state.protocol_control_high;
      end
      sce_off_protocol_status: begin
        read_word[15:0] = protocol_status_register;
      end
      sce_off_status_clear: begin
        read_word = '0;
      end
      sce_off_node_pointer_low: begin
        read_word[15:0] = state.node_pointer_low;
      end
      sce_off_node_pointer_high: begin
        read_word[15:0] = state.node_pointer_high;
      end
      default: begin
        read_hit = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    next_state = state;
    if (s_axi_awvalid && s_axi_awready) begin
      next_state.aw_have = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_state.w_have = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    if (write_fire) begin
      next_state.aw_have = 1'b0;
      next_state.w_have = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = sce_resp_okay;
      case (state.aw_addr)
        sce_off_channel_control: begin
          // mode codes are stored as written; decode keeps bad ones disabled
          next_state.channel_control = sce_merge(state.channel_control, state.w_data,
            state.w_strb, sce_wmask_channel_control); // [R17] [R09]
        end
        sce_off_protocol_control_low: begin
          next_state.protocol_control_low = sce_merge(state.protocol_control_low,
            state.w_data, state.w_strb, 16'hFFFF);
        end
        sce_off_protocol_control_high: begin
          next_state.protocol_control_high = sce_merge(state.protocol_control_high,
            state.w_data, state.w_strb, 16'hFFFF);
        end
        sce_off_protocol_status: begin
          next_state.bresp = sce_resp_okay;
        end
        sce_off_status_clear: begin
          next_state.bresp = sce_resp_okay;
        end
        sce_off_node_pointer_low: begin
          next_state.node_pointer_low = sce_merge(state.node_pointer_low, state.w_data,
            state.w_strb, sce_wmask_node_pointer_low);
        end
        sce_off_node_pointer_high: begin
          next_state.node_pointer_high = sce_merge(state.node_pointer_high, state.w_data,
            state.w_strb, sce_wmask_node_pointer_high);
        end
        default: begin
          next_state.bresp = sce_resp_slverr;
        end
      endcase
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_state.rvalid = 1'b1;
      next_state.rdata = read_word;
      next_state.rresp = read_hit ? sce_resp_okay : sce_resp_slverr;
    end
    // request lines pulse one cycle after the event
    next_state.service_request = '0;
    next_state.service_request = sce_route(next_state.service_request,
      set_flags[sce_pos_rx_start_en] & state.channel_control[sce_pos_rx_start_en],
      state.node_pointer_low[sce_pos_tx_buffer_ptr +: 3]); // [R12]
    next_state.service_request = sce_route(next_state.service_request,
      set_flags[sce_pos_data_lost_en] & state.channel_control[sce_pos_data_lost_en],
      state.node_pointer_high[sce_pos_protocol_ptr +: 3]); // [R13]
    next_state.service_request = sce_route(next_state.service_request,
      set_flags[sce_pos_tx_shift_en] & state.channel_control[sce_pos_tx_shift_en],
      state.node_pointer_low[sce_pos_tx_shift_ptr +: 3]); // [R14]
    next_state.service_request = sce_route(next_state.service_request,
      set_flags[sce_pos_tx_buffer_en] & state.channel_control[sce_pos_tx_buffer_en],
      state.node_pointer_low[sce_pos_tx_buffer_ptr +: 3]); // [R15]
    next_state.service_request = sce_route(next_state.service_request,
      set_flags[sce_pos_receive_en] & state.channel_control[sce_pos_receive_en],
      state.node_pointer_low[sce_pos_receive_ptr +: 3]); // [R15]
    next_state.service_request = sce_route(next_state.service_request,
      set_flags[sce_pos_alt_receive_en] & state.channel_control[sce_pos_alt_receive_en],
      state.node_pointer_low[sce_pos_alt_receive_ptr +: 3]); // [R15]
    next_state.service_request = sce_route(next_state.service_request, proto_fire,
      state.node_pointer_high[sce_pos_protocol_ptr +: 3]); // [R02]
  end

  // ==========================================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
      state.channel_control <= sce_rst_channel_control; // [R17]
      state.protocol_control_low <= sce_rst_protocol_control;
      state.protocol_control_high <= sce_rst_protocol_control;
      state.node_pointer_low <= sce_rst_node_pointer;
      state.node_pointer_high <= sce_rst_node_pointer;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // bus outputs
  // one write in flight keeps the response ordering trivial
  assign s_axi_awready = !state.aw_have && !state.bvalid;
  assign s_axi_wready = !state.w_have && !state.bvalid;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_arready = !state.rvalid;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign service_request_output = state.service_request;
endmodule // sce_channel_events

// ---- test/sce_channel_events_properties.sv ----
// concurrent checks on the serial channel event block ports
// assumes single aclk domain, bound into the top module by the bench
`timescale 1ns/1ns
// ==========================================================
// checker
module sce_channel_events_properties
  import sce_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic receive_event,
  input wire logic rx_start_event,
  input wire logic alt_receive_event,
  input wire logic tx_shift_event,
  input wire logic tx_buffer_event,
  input wire logic data_lost_event,
  input wire logic [8:1] protocol_event,
  input wire logic channel_active,
  input wire logic protocol_force_idle,
  input wire logic sync_serial_mode,
  input wire logic async_serial_mode,
  input wire logic i2c_mode,
  input wire logic i2s_mode,
  input wire logic [1:0] parity_mode,
  input wire logic parity_enable,
  input wire logic parity_odd,
  input wire logic [sce_num_sr-1:0] service_request_output
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_no_event;
    !(receive_event || rx_start_event || alt_receive_event || tx_shift_event ||
      tx_buffer_event || data_lost_event || (|protocol_event));
  endsequence
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_force_idle: assert property (protocol_force_idle == !channel_active)
    else $error("force idle does not follow channel state");
  a_mode_onehot: assert property ($onehot0({sync_serial_mode, async_serial_mode,
    i2c_mode, i2s_mode})) else $error("more than one protocol decoded");
  a_active_mode: assert property (channel_active == |{sync_serial_mode, async_serial_mode,
    i2c_mode, i2s_mode}) else $error("active without a valid protocol");
  a_parity_odd: assert property (parity_odd == (parity_mode == 2'h3))
    else $error("odd parity decode wrong");
  a_parity_on: assert property (parity_enable == parity_mode[1])
    else $error("parity enable decode wrong");
  a_request_cause: assert property ((|service_request_output) |-> $past(channel_active))
    else $error("request without an active channel");
  a_idle_quiet: assert property (!channel_active |=> service_request_output == 6'h00)
    else $error("request while channel disabled");
  a_request_source: assert property (s_no_event |=> service_request_output == 6'h00)
    else $error("request without an event");
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer stuck");
  a_write_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
endmodule // sce_channel_events_properties

// ---- test/sce_irq_sink.sv ----
// model of the interrupt control side: counts request pulses
// assumes requests are one-cycle pulses on aclk
`timescale 1ns/1ns
// ==========================================================
// request counter
module sce_irq_sink
  import sce_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sce_num_sr-1:0] service_request_output,
  output int pulses_seen
);
  // a level held two cycles counts twice, so stretched pulses show up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulses_seen <= 0;
    end else begin
      pulses_seen <= pulses_seen + $countones(service_request_output);
    end
  end
endmodule // sce_irq_sink

// ---- test/serial_channel_event_control_test.sv ----
// self-checking bench for the serial channel event block
// assumes the design package and both test modules are compiled first
`timescale 1ns/1ns
// ==========================================================
// bench
module serial_channel_event_control_test;
  import sce_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, parity_mode;
  logic receive_event = 0, rx_start_event = 0, alt_receive_event = 0;
  logic tx_shift_event = 0, tx_buffer_event = 0, data_lost_event = 0;
  logic [8:1] protocol_event = 8'h00;
  logic channel_active, protocol_force_idle, sync_serial_mode, async_serial_mode;
  logic i2c_mode, i2s_mode, parity_enable, parity_odd;
  logic [5:0] service_request_output;
  logic [33:0] bus_q[$];
  logic [5:0] sr_q[$];
  int error_cnt = 0, samples_checked = 0, pulses_exp = 0, pulses_seen;
  logic [31:0] rng = 32'h09787364;
  logic [15:0] c;
  logic ok;
  logic [3:0] pm[4] = '{4'h3, 4'h1, 4'h4, 4'h2};
  logic [15:0] pl[4] = '{16'h00F8, 16'hC000, 16'h0000, 16'h8070};
  logic [15:0] ph[4] = '{16'h0000, 16'h0000, 16'h01FC, 16'h0000};
  logic [8:0] pk[4] = '{9'h1FC, 9'h00C, 9'h1FE, 9'h078};
  logic [5:0] dx[6] = '{6'h04, 6'h02, 6'h08, 6'h01, 6'h02, 6'h10};
  always #2 aclk = ~aclk;
  sce_channel_events i_dut (.*);
  sce_irq_sink i_sink (.*);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================
  // bus master and event driver
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
    logic at, wt, bt;
    bus_q.push_back({32'h0, r});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= {16'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(negedge aclk);
      at = s_axi_awready;
      wt = s_axi_wready;
      bt = s_axi_bvalid;
      @(posedge aclk);
      if (at) s_axi_awvalid <= 0;
      if (wt) s_axi_wvalid <= 0;
    end while (bt !== 1'b1);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] r);
    logic at, rt;
    bus_q.push_back({16'h0, e, r});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(negedge aclk);
      at = s_axi_arready;
      rt = s_axi_rvalid;
      @(posedge aclk);
      if (at) s_axi_arvalid <= 0;
    end while (rt !== 1'b1);
    s_axi_rready <= 0;
  endtask
  task automatic pulse(input logic [5:0] e, input logic [8:1] p, input logic [5:0] x);
    @(posedge aclk);
    {data_lost_event, tx_buffer_event, tx_shift_event, alt_receive_event, rx_start_event,
      receive_event} <= e;
    protocol_event <= p;
    @(posedge aclk);
    {data_lost_event, tx_buffer_event, tx_shift_event, alt_receive_event, rx_start_event,
      receive_event} <= 6'h00;
    protocol_event <= 8'h00;
    sr_q.push_back(x);
    pulses_exp += $countones(x);
  endtask
  // ==========================================================
  // result monitor: answers and requests are settled at the falling edge
  always @(negedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) check({s_axi_rdata, s_axi_rresp}, bus_q.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready) check({32'h0, s_axi_bresp}, bus_q.pop_front());
    if (sr_q.size() > 0) check({28'h0, service_request_output}, {28'h0, sr_q.pop_front()});
  end
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    print_verdict;
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(sce_off_channel_control, 16'h0000, sce_resp_okay);
    rd(8'h00, 16'h0000, sce_resp_slverr);
    wr(8'h04, 16'h1234, sce_resp_slverr);
    wr(sce_off_channel_control, 16'hFFFF, sce_resp_okay);
    rd(sce_off_channel_control, 16'hFF0F, sce_resp_okay);
    for (int i = 0; i < 16; i++) begin
      c = {6'h0, i[1:0], 4'h0, i[3:0]};
      ok = (i >= 1 && i <= 4);
      wr(sce_off_channel_control, c, sce_resp_okay);
      @(negedge aclk);
      check({24'h0, channel_active, protocol_force_idle, sync_serial_mode, async_serial_mode,
        i2c_mode, i2s_mode, parity_mode, parity_enable, parity_odd},
        {24'h0, ok, !ok, i == 1, i == 3, i == 4, i == 2, c[9:8], c[9], c[9:8] == 2'h3});
    end
    rng = xs(rng);
    wr(sce_off_node_pointer_low, rng[15:0], sce_resp_okay);
    rd(sce_off_node_pointer_low, rng[15:0] & 16'h7777, sce_resp_okay);
    wr(sce_off_node_pointer_low, 16'h3210, sce_resp_okay);
    wr(sce_off_node_pointer_high, 16'h0004, sce_resp_okay);
    for (int k = 0; k < 4; k++) begin
      // disable first, then rewrite controls before the new protocol
      wr(sce_off_channel_control, 16'h0000, sce_resp_okay);
      wr(sce_off_protocol_control_low, pl[k], sce_resp_okay);
      wr(sce_off_protocol_control_high, ph[k], sce_resp_okay);
      wr(sce_off_status_clear, 16'hFFFF, sce_resp_okay);
      wr(sce_off_channel_control, {12'h0, pm[k]}, sce_resp_okay);
      for (int b = 1; b <= 8; b++) pulse(6'h00, 8'h01 << (b - 1), pk[k][b] ? 6'h10 : 6'h00);
      rd(sce_off_protocol_status, {7'h0, pk[k]}, sce_resp_okay);
      wr(sce_off_status_clear, 16'hFFFF, sce_resp_okay);
      rd(sce_off_protocol_status, 16'h0000, sce_resp_okay);
    end
    wr(sce_off_channel_control, 16'hFC03, sce_resp_okay);
    for (int e = 0; e < 6; e++) pulse(6'h01 << e, 8'h00, dx[e]);
    rd(sce_off_protocol_status, 16'hFC00, sce_resp_okay);
    pulse(6'h12, 8'h00, 6'h02);
    pulse(6'h01, 8'h00, 6'h04);
    wr(sce_off_status_clear, 16'h4000, sce_resp_okay);
    rd(sce_off_protocol_status, 16'hBC00, sce_resp_okay);
    wr(sce_off_channel_control, 16'h0003, sce_resp_okay);
    pulse(6'h3F, 8'h00, 6'h00);
    wr(sce_off_channel_control, 16'hFC00, sce_resp_okay);
    pulse(6'h3F, 8'hFF, 6'h00);
    repeat (3) @(posedge aclk);
    check(pulses_seen, pulses_exp);
    print_verdict;
  end
endmodule // serial_channel_event_control_test
bind sce_channel_events sce_channel_events_properties i_props (.*);
